// file: hw/byte_fifo.sv
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_i, // clock
    input wire logic resetn_i, // sync reset, active low
    input wire logic [WIDTH-1:0] in_data_i, // write word
    input wire logic in_valid_i, // write request
    output logic in_ready_o, // not full
    output logic [WIDTH-1:0] out_data_o, // head word
    output logic out_valid_o, // not empty
    input wire logic out_ready_i // read accept
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic [AW:0] count_next;
    logic not_full_reg;
    logic not_empty_reg;
    logic push;
    logic pop;

    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign count_next = (AW+1)'(count_reg + push - pop);
    // flags are registered so both handshake outputs leave flip-flops
    assign in_ready_o = not_full_reg;
    assign out_valid_o = not_empty_reg;
    assign out_data_o = mem_reg[rd_ptr_reg];

    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            not_full_reg <= 1'b1;
            not_empty_reg <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
            end
            if (pop)
            begin
                rd_ptr_reg <= AW'(rd_ptr_reg + 1'b1);
            end
            count_reg <= count_next;
            not_empty_reg <= (count_next != '0);
            not_full_reg <= (count_next != (AW+1)'(DEPTH));
        end
    end
endmodule : byte_fifo

// file: hw/framer_pkg.sv
package framer_pkg;

    localparam int BYTE_W = 8;
    localparam int CW_W = 8;
    localparam int CAP_W = 16;
    localparam logic [CW_W-1:0] MIN_INFO_BYTES = 8'h10;
    localparam int FIFO_DEPTH = 16;

    typedef enum logic [0:0]
    {
        MODE_FIXED = 1'b0,
        MODE_SHORTENED = 1'b1
    } cw_mode_e;

    // burst setup, captured on start_i
    typedef struct packed
    {
        cw_mode_e mode;
        logic [CW_W-1:0] info_bytes;
        logic [CW_W-1:0] parity_bytes;
        logic [CAP_W-1:0] burst_bytes;
        logic [CAP_W-1:0] grant_bytes;
        logic [CW_W-1:0] guard_bytes;
    } burst_cfg_s;

    // one output byte with its framing marks
    typedef struct packed
    {
        logic [BYTE_W-1:0] data;
        logic fill;
        logic cw_first;
        logic cw_last;
        logic burst_last;
    } out_byte_s;

    localparam int OUT_W = $bits(out_byte_s);

    typedef enum logic [3:0]
    {
        ST_IDLE = 4'b0001,
        ST_DATA = 4'b0010,
        ST_FILL = 4'b0100,
        ST_DONE = 4'b1000
    } frame_state_e;

endpackage : framer_pkg

// file: hw/upstream_fec_codeword_framer.sv
`timescale 1ns/1ps
module upstream_fec_codeword_framer (
    input wire logic clk_i, // 250 MHz clock
    input wire logic resetn_i, // sync reset, active low
    input wire logic start_i, // one-cycle burst start
    input wire framer_pkg::burst_cfg_s cfg_i, // burst setup
    input wire logic [framer_pkg::BYTE_W-1:0] in_data_i, // burst byte
    input wire logic in_valid_i, // burst byte valid
    output logic in_ready_o, // burst byte taken
    output framer_pkg::out_byte_s out_data_o, // framed byte
    output logic out_valid_o, // framed byte valid
    input wire logic out_ready_i, // encoder accepts
    output logic busy_o, // burst in progress
    output logic done_o // one-cycle burst end
);
    localparam int CAP_W = framer_pkg::CAP_W;
    localparam int CW_W = framer_pkg::CW_W;

    framer_pkg::burst_cfg_s cfg_reg;
    framer_pkg::frame_state_e state_reg;
    logic [CAP_W-1:0] cap_reg;
    logic [CAP_W-1:0] data_left_reg;
    logic [CW_W-1:0] cw_len_reg;
    logic [CW_W-1:0] cw_pos_reg;
    logic in_ready_reg;
    logic busy_reg;
    logic done_reg;
    logic fifo_in_valid;
    logic fifo_in_ready;
    framer_pkg::out_byte_s fifo_in_data;
    logic [framer_pkg::OUT_W-1:0] fifo_out_bits;
    logic [CW_W-1:0] k_eff;
    logic [CAP_W-1:0] overhead;
    logic [CAP_W-1:0] avail;
    logic take;
    logic cw_start;
    logic cw_end;
    logic [framer_pkg::BYTE_W-1:0] hold_data_reg;
    logic hold_valid_reg;
    logic hold_next;
    logic load;
    logic consume;
    logic [CAP_W-1:0] left_after;

    // bytes still usable for information after one codeword's overhead
    function automatic logic [CAP_W-1:0] usable(
        input logic [CAP_W-1:0] cap,
        input logic [CAP_W-1:0] ovh
    );
        usable = (cap > ovh) ? CAP_W'(cap - ovh) : '0;
    endfunction : usable

    // true when a codeword (full, or shortened in that mode) still fits
    function automatic logic fits(
        input logic [CAP_W-1:0] av,
        input logic [CW_W-1:0] k,
        input framer_pkg::cw_mode_e mode
    );
        fits = (av >= CAP_W'(k))
            || (mode == framer_pkg::MODE_SHORTENED
            && av >= CAP_W'(framer_pkg::MIN_INFO_BYTES));
    endfunction : fits

    ////////////////////////////////////////////////////////////////////////
    // fit decisions

    assign k_eff = (cfg_reg.info_bytes < framer_pkg::MIN_INFO_BYTES)
        ? framer_pkg::MIN_INFO_BYTES : cfg_reg.info_bytes;
    assign overhead = CAP_W'(cfg_reg.parity_bytes);
    assign avail = usable(cap_reg, overhead);
    assign cw_start = (cw_pos_reg == '0);
    assign cw_end = (cw_pos_reg == CW_W'(cw_len_reg - 1'b1));
    assign take = fifo_in_valid && fifo_in_ready;

    // grant is identical for contention or not: no region input exists
    // the requester guarantees capacity for a 16-byte short codeword

    ////////////////////////////////////////////////////////////////////////
    // byte generation

    always_comb
    begin
        fifo_in_valid = 1'b0;
        fifo_in_data = '0;
        if ((state_reg == framer_pkg::ST_DATA
                || state_reg == framer_pkg::ST_FILL) && !cw_start)
        begin
            fifo_in_valid = (state_reg == framer_pkg::ST_FILL)
                || (data_left_reg == '0) || hold_valid_reg;
        end
        else if (state_reg == framer_pkg::ST_DATA
                || state_reg == framer_pkg::ST_FILL)
        begin
            fifo_in_valid = (cw_len_reg != '0)
                && ((state_reg == framer_pkg::ST_FILL)
                || (data_left_reg == '0) || hold_valid_reg);
        end
        fifo_in_data.fill = (data_left_reg == '0)
            || (state_reg == framer_pkg::ST_FILL);
        fifo_in_data.data = fifo_in_data.fill ? '0 : hold_data_reg;
        fifo_in_data.cw_first = cw_start;
        fifo_in_data.cw_last = cw_end;
        // last byte of the burst when no further codeword fits
        fifo_in_data.burst_last = cw_end && !fits(
            usable(CAP_W'(cap_reg - cw_len_reg - overhead), overhead),
            k_eff, cfg_reg.mode);
    end

    ////////////////////////////////////////////////////////////////////////
    // input holding byte; ready is a flop, so one byte per two cycles

    assign load = in_valid_i && in_ready_reg;
    assign consume = take && !fifo_in_data.fill;
    assign hold_next = load || (hold_valid_reg && !consume);
    assign left_after = CAP_W'(data_left_reg - CAP_W'(consume));
    assign in_ready_o = in_ready_reg;

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            in_ready_reg <= 1'b0;
            hold_valid_reg <= 1'b0;
            hold_data_reg <= '0;
        end
        else
        begin
            hold_valid_reg <= hold_next
                && (state_reg != framer_pkg::ST_IDLE);
            if (load)
            begin
                hold_data_reg <= in_data_i;
            end
            // never ask for more bytes than the burst still holds
            in_ready_reg <= (state_reg == framer_pkg::ST_DATA)
                && !hold_next && (left_after != '0);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // codeword sequencer

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            state_reg <= framer_pkg::ST_IDLE;
            cfg_reg <= '0;
            cap_reg <= '0;
            data_left_reg <= '0;
            cw_len_reg <= '0;
            cw_pos_reg <= '0;
        end
        else
        begin
            case (state_reg)
            framer_pkg::ST_IDLE:
            begin
                if (start_i)
                begin
                    cfg_reg <= cfg_i;
                    cap_reg <= CAP_W'(cfg_i.grant_bytes - cfg_i.guard_bytes);
                    data_left_reg <= cfg_i.burst_bytes;
                    cw_pos_reg <= '0;
                    cw_len_reg <= '0;
                    state_reg <= framer_pkg::ST_DATA;
                end
            end
            framer_pkg::ST_DATA, framer_pkg::ST_FILL:
            begin
                if (cw_start && cw_len_reg == '0)
                begin
                    // choose next codeword length from remaining capacity
                    if (avail >= CAP_W'(k_eff))
                    begin
                        cw_len_reg <= k_eff;
                    end
                    else if (fits(avail, k_eff, cfg_reg.mode))
                    begin
                        cw_len_reg <= avail[CW_W-1:0];
                    end
                    else
                    begin
                        state_reg <= framer_pkg::ST_DONE;
                    end
                end
                else if (take)
                begin
                    if (!fifo_in_data.fill)
                    begin
                        data_left_reg <= CAP_W'(data_left_reg - 1'b1);
                    end
                    if (cw_end)
                    begin
                        cap_reg <= CAP_W'(cap_reg - cw_len_reg - overhead);
                        cw_pos_reg <= '0;
                        cw_len_reg <= '0;
                        if (data_left_reg <= 16'h0001)
                        begin
                            state_reg <= framer_pkg::ST_FILL;
                        end
                    end
                    else
                    begin
                        cw_pos_reg <= CW_W'(cw_pos_reg + 1'b1);
                    end
                end
            end
            framer_pkg::ST_DONE:
            begin
                state_reg <= framer_pkg::ST_IDLE;
            end
            default:
            begin
                state_reg <= framer_pkg::ST_IDLE;
            end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else
        begin
            busy_reg <= (state_reg != framer_pkg::ST_IDLE) || start_i;
            done_reg <= (state_reg == framer_pkg::ST_DONE);
        end
    end

    assign busy_o = busy_reg;
    assign done_o = done_reg;

    ////////////////////////////////////////////////////////////////////////
    // output buffer; its ready stalls the sequencer

    byte_fifo #(
        .WIDTH(framer_pkg::OUT_W),
        .DEPTH(framer_pkg::FIFO_DEPTH)
    ) u_out_fifo (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .in_data_i(fifo_in_data),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .out_data_o(fifo_out_bits),
        .out_valid_o(out_valid_o),
        .out_ready_i(out_ready_i)
    );

    assign out_data_o = framer_pkg::out_byte_s'(fifo_out_bits);
endmodule : upstream_fec_codeword_framer

// file: verif/encoder_sink.sv
`timescale 1ns/1ps
module encoder_sink (
    input wire logic clk_i, // clock
    input wire logic slow_i, // stall at random when high
    output logic ready_o // accept toward framer
);
    initial ready_o = 1'b0;
    // same acceptance for any grant kind
    always @(posedge clk_i)
    begin
        #1 ready_o = !slow_i || ($urandom % 3 == 0);
    end
endmodule : encoder_sink

// file: verif/framer_assertions.sv
`timescale 1ns/1ps
module framer_assertions (
    input wire logic clk_i, // clock
    input wire logic resetn_i, // reset, low
    input wire logic start_i, // start
    input wire framer_pkg::burst_cfg_s cfg_i, // setup
    input wire logic [framer_pkg::BYTE_W-1:0] in_data_i, // byte in
    input wire logic in_valid_i, // byte valid
    input wire logic in_ready_o, // byte taken
    input wire framer_pkg::out_byte_s out_data_o, // byte out
    input wire logic out_valid_o, // out valid
    input wire logic out_ready_i, // out accept
    input wire logic busy_o, // busy
    input wire logic done_o // done
);
    logic acc;
    logic [7:0] cnt_reg, k_reg, par_reg;
    logic [15:0] used_reg, cap_reg;
    logic fixed_reg, fill_reg, first_reg;
    assign acc = out_valid_o && out_ready_i;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    always_ff @(posedge clk_i)
    begin
        if (start_i && !busy_o)
        begin
            k_reg <= (cfg_i.info_bytes < framer_pkg::MIN_INFO_BYTES) ?
                framer_pkg::MIN_INFO_BYTES : cfg_i.info_bytes;
            par_reg <= cfg_i.parity_bytes;
            cap_reg <= cfg_i.grant_bytes - 16'(cfg_i.guard_bytes);
            fixed_reg <= cfg_i.mode == framer_pkg::MODE_FIXED;
        end
    end

    // byte and grant usage per codeword and per burst
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i || (acc && out_data_o.burst_last))
        begin
            cnt_reg <= 8'h00;
            used_reg <= 16'h0000;
            fill_reg <= 1'b0;
            first_reg <= 1'b1;
        end
        else if (acc)
        begin
            cnt_reg <= out_data_o.cw_last ? 8'h00 : cnt_reg + 8'h01;
            used_reg <= used_reg + 16'h0001 +
                (out_data_o.cw_last ? 16'(par_reg) : 16'h0000);
            fill_reg <= fill_reg | out_data_o.fill;
            first_reg <= out_data_o.cw_last;
        end
    end

    AST_OUT_HOLD: assert property (
        out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
        else $error("output byte changed before accept");
    AST_FILL_ZERO: assert property (
        out_valid_o && out_data_o.fill |-> out_data_o.data == 8'h00)
        else $error("fill byte not zero");
    AST_CW_MIN: assert property (
        acc && out_data_o.cw_last |->
        cnt_reg >= framer_pkg::MIN_INFO_BYTES - 8'h01)
        else $error("codeword shorter than minimum");
    AST_CW_MAX: assert property (
        acc && out_data_o.cw_last |-> cnt_reg < k_reg)
        else $error("codeword longer than k");
    AST_FIXED_LEN: assert property (
        acc && out_data_o.cw_last && fixed_reg |-> cnt_reg + 8'h01 == k_reg)
        else $error("fixed codeword not k bytes");
    AST_CW_FIRST: assert property (
        acc |-> out_data_o.cw_first == first_reg)
        else $error("codeword start mark misplaced");
    AST_DATA_FIRST: assert property (
        acc && fill_reg |-> out_data_o.fill)
        else $error("burst byte after fill");
    AST_GRANT_FIT: assert property (
        acc && out_data_o.burst_last |->
        17'(used_reg) + 17'(par_reg) + 17'h00001 <= 17'(cap_reg))
        else $error("burst overruns grant");
    AST_START_BUSY: assert property (
        start_i && !busy_o |=> busy_o [*2])
        else $error("start not followed by busy");

    cover property (done_o && !fixed_reg);
    cover property (acc && out_data_o.fill && out_data_o.cw_first);
    cover property (out_valid_o && !out_ready_i && in_valid_i && !in_ready_o);
endmodule : framer_assertions

// file: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam framer_pkg::cw_mode_e m_fix = framer_pkg::MODE_FIXED;
    localparam framer_pkg::cw_mode_e m_sht = framer_pkg::MODE_SHORTENED;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic start = 1'b0;
    logic in_valid = 1'b0;
    logic slow = 1'b0;
    logic [7:0] in_data = 8'h00;
    logic in_ready, out_valid, out_ready, busy, done;
    framer_pkg::burst_cfg_s cfg = '0;
    framer_pkg::burst_cfg_s tbl[5];
    framer_pkg::out_byte_s out_data, e;
    framer_pkg::out_byte_s exp_q[$];
    logic [7:0] in_q[$];
    int n_fail = 0;
    int compares = 0;
    int n_done = 0;

    always #2 clk = ~clk;

    upstream_fec_codeword_framer upstream_fec_codeword_framer_i (
        .clk_i(clk), .resetn_i(resetn), .start_i(start), .cfg_i(cfg),
        .in_data_i(in_data), .in_valid_i(in_valid), .in_ready_o(in_ready),
        .out_data_o(out_data), .out_valid_o(out_valid),
        .out_ready_i(out_ready), .busy_o(busy), .done_o(done));
    encoder_sink encoder_sink_i (.clk_i(clk), .slow_i(slow),
        .ready_o(out_ready));

    task automatic close_out();
        if (n_fail == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    task automatic check(input string name, input logic [15:0] x, y);
        compares++;
        if (x !== y)
        begin
            n_fail++;
            $display("Error %s exp %h got %h", name, x, y);
        end
    endtask : check

    // expected layout: data codewords, full zero ones, at most one short last one that may still hold data
    task automatic plan(input framer_pkg::burst_cfg_s c);
        int cap, av, len, rem, k, nd;
        framer_pkg::out_byte_s b;
        k = (c.info_bytes < 8'h10) ? 16 : int'(c.info_bytes);
        cap = int'(c.grant_bytes) - int'(c.guard_bytes);
        rem = int'(c.burst_bytes);
        nd = 0;
        for (int i = 0; i < rem; i++)
            in_q.push_back(8'($urandom));
        while (1)
        begin
            av = cap - int'(c.parity_bytes);
            if (av < 16)
                break;
            len = (rem >= k || c.mode == m_fix || av >= k) ? k : av;
            if (len > av)
                break;
            for (int j = 0; j < len; j++)
            begin
                b = '0;
                if (rem > 0)
                begin
                    b.data = in_q[nd];
                    nd++;
                    rem--;
                end
                else
                    b.fill = 1'b1;
                b.cw_first = (j == 0);
                b.cw_last = (j == len - 1);
                exp_q.push_back(b);
            end
            cap -= len + int'(c.parity_bytes);
        end
        exp_q[exp_q.size() - 1].burst_last = 1'b1;
    endtask : plan

    task automatic run(input framer_pkg::burst_cfg_s c, input logic s);
        int n;
        logic taken;
        slow = s;
        plan(c);
        cfg = c;
        start = 1'b1;
        @(posedge clk);
        #1 start = 1'b0;
        while (in_q.size() > 0)
        begin
            in_valid = 1'b1;
            in_data = in_q[0];
            #2 taken = in_ready;
            @(posedge clk);
            #1;
            if (taken === 1'b1)
                void'(in_q.pop_front());
        end
        in_valid = 1'b0;
        n = 0;
        while ((busy !== 1'b0 || exp_q.size() > 0) && n < 3000)
        begin
            @(posedge clk);
            #1 n++;
        end
        check("drain", 16'h0000, 16'(exp_q.size()));
        check("idle", 16'h0000, 16'(busy));
    endtask : run

    always @(posedge clk)
    begin
        if (done === 1'b1)
            n_done++;
        if (resetn && out_valid === 1'b1 && out_ready === 1'b1)
        begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
            check("byte", 16'({e.data, e.fill}),
                16'({out_data.data, out_data.fill}));
            check("marks", 16'({e.cw_first, e.cw_last, e.burst_last}),
                16'({out_data.cw_first, out_data.cw_last,
                out_data.burst_last}));
        end
    end

    initial
    begin
        tbl[0] = '{m_fix, 8'h14, 8'h04, 16'h002D, 16'h0064, 8'h06};
        tbl[1] = '{m_fix, 8'h08, 8'h02, 16'h0010, 16'h003C, 8'h04};
        tbl[2] = '{m_sht, 8'h20, 8'h04, 16'h0024, 16'h003C, 8'h04};
        tbl[3] = '{m_sht, 8'h20, 8'h04, 16'h0020, 16'h006E, 8'h04};
        tbl[4] = '{m_sht, 8'h20, 8'h04, 16'h0020, 16'h005C, 8'h04};
        void'($urandom(32'hB4C8240C));
        repeat (6) @(posedge clk);
        #1 resetn = 1'b1;
        for (int t = 0; t < 5; t++)
            run(tbl[t], t[0]);
        check("done", 16'h0005, 16'(n_done));
        close_out();
    end

    initial
    begin
        #80000;
        n_fail++;
        close_out();
    end
endmodule : tb_top

bind upstream_fec_codeword_framer framer_assertions framer_assertions_i (
    .clk_i(clk_i), .resetn_i(resetn_i), .start_i(start_i), .cfg_i(cfg_i),
    .in_data_i(in_data_i), .in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
    .out_data_o(out_data_o), .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i), .busy_o(busy_o), .done_o(done_o));
